//--- flpm_pkg.sv
// package: offsets, field positions, reset values and timing for the fifo level / power registers
package flpm_pkg;
  localparam logic [7:0] OFS_BYTE_ORDER_TEST = 8'h64;
  localparam logic [7:0] OFS_RX_FIFO_LEVELS = 8'h7c;
  localparam logic [7:0] OFS_TX_FIFO_LEVELS = 8'h80;
  localparam logic [7:0] OFS_POWER_MGMT = 8'h84;
  localparam int POS_STATE = 12;
  localparam int POS_PHY_RESET_REQUEST = 10;
  localparam int POS_WAKE_ON_LAN_ENABLE = 9;
  localparam int POS_ENERGY_DETECT_ENABLE = 8;
  localparam int POS_DRV_TYPE = 6;
  localparam int POS_WAKE_CAUSE = 4;
  localparam int POS_PULSE_MODE = 3;
  localparam int POS_POLARITY = 2;
  localparam int POS_OUT_EN = 1;
  localparam int POS_READY = 0;
  localparam logic [15:0] TX_FREE_RESET = 16'h1200;
  localparam logic [1:0] PS_NORMAL = 2'h0;
  localparam logic [1:0] PS_WAKE_FRAME = 2'h1;
  localparam logic [1:0] PS_ENERGY = 2'h2;
  localparam logic [1:0] PS_RESERVED = 2'h3;
  localparam int CLK_MHZ = 200;
  localparam int PHY_RESET_REQUEST_US = 100;
  localparam int PHY_RESET_REQUEST_CYCLES = PHY_RESET_REQUEST_US * CLK_MHZ;
  localparam int WAKE_PULSE_MS = 50;
  localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int READY_DELAY_CYCLES = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } flpm_bus_req_t;

  typedef struct packed {
    logic [7:0] rx_status_words_used;
    logic [15:0] rx_data_bytes_used;
    logic [7:0] tx_status_words_used;
    logic [15:0] tx_data_bytes_free;
  } flpm_levels_t;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_WAKING = 2'b11
  } flpm_pwr_t;
endpackage

//--- flpm_regs.sv
// fifo level reporting and power-management control register bank
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module flpm_regs #(
  parameter int PHY_RESET_REQUEST_LEN = flpm_pkg::PHY_RESET_REQUEST_CYCLES,
  parameter int WAKE_PULSE_LEN = flpm_pkg::WAKE_PULSE_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire flpm_pkg::flpm_bus_req_t i_bus,
  output logic [31:0] o_rdata,
  input wire flpm_pkg::flpm_levels_t i_levels,
  input wire logic i_wol_event,
  input wire logic i_energy_event,
  input wire logic i_events_pending,
  output logic o_phy_reset,
  output logic [1:0] o_power_state,
  output logic o_wake_internal_interrupt,
  output logic o_wake_event_output,
  output logic o_wake_event_output_en
);
  import flpm_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    flpm_pwr_t pwr;
    logic [1:0] state_sel;
    logic phy_reset_request;
    logic [31:0] phy_cnt;
    logic wake_on_lan_enable;
    logic energy_detect_enable;
    logic drv_type;
    logic [1:0] cause;
    logic pulse_mode;
    logic polarity;
    logic out_en;
    logic ready;
    logic [4:0] rdy_cnt;
    logic read_seen;
    logic [31:0] pulse_cnt;
    logic wake_active;
    logic pin_out;
    logic pin_oe;
    logic irq;
  } flpm_state_t;

  flpm_state_t st;
  flpm_state_t next_st;

  logic wr_pm;
  logic wr_bot;
  logic wr_ok;
  logic wol_hit;
  logic ed_hit;
  logic [31:0] pm_word;
  logic asserted;

  always_comb begin
    pm_word = '0;
    pm_word[POS_STATE +: 2] = st.state_sel;
    pm_word[POS_PHY_RESET_REQUEST] = st.phy_reset_request;
    pm_word[POS_WAKE_ON_LAN_ENABLE] = st.wake_on_lan_enable;
    pm_word[POS_ENERGY_DETECT_ENABLE] = st.energy_detect_enable;
    pm_word[POS_DRV_TYPE] = st.drv_type;
    pm_word[POS_WAKE_CAUSE +: 2] = st.cause;
    pm_word[POS_PULSE_MODE] = st.pulse_mode;
    pm_word[POS_POLARITY] = st.polarity;
    pm_word[POS_OUT_EN] = st.out_en;
    pm_word[POS_READY] = st.ready;
  end

  // events count only while their enable is set
  assign wol_hit = i_wol_event && st.wake_on_lan_enable;
  assign ed_hit = i_energy_event && st.energy_detect_enable;
  // power register writes do nothing until software has read once since reset or wake
  assign wr_ok = i_bus.wr && st.read_seen;
  assign wr_pm = wr_ok && (i_bus.addr == OFS_POWER_MGMT) && st.ready;
  // the wake write needs neither a first read nor ready, so a sleeping part wakes on it as on an enabled event
  assign wr_bot = i_bus.wr && (i_bus.addr == OFS_BYTE_ORDER_TEST);

  always_comb begin
    next_st = st;
    // -------------------------------------------------------------
    // read path, data stand one cycle after the strobe
    // -------------------------------------------------------------
    next_st.rdata = '0;
    if (i_bus.rd) begin
      next_st.read_seen = 1'b1;
      case (i_bus.addr)
        // fifo levels hide behind ready, a half-awake part would show stale counts
        OFS_RX_FIFO_LEVELS: begin
          if (st.ready) begin
            next_st.rdata = {8'h00, i_levels.rx_status_words_used, i_levels.rx_data_bytes_used};
          end
        end
        OFS_TX_FIFO_LEVELS: begin
          if (st.ready) begin
            next_st.rdata = {8'h00, i_levels.tx_status_words_used, i_levels.tx_data_bytes_free};
          end
        end
        OFS_POWER_MGMT: next_st.rdata = pm_word;
        default: next_st.rdata = '0;
      endcase
    end
    // -------------------------------------------------------------
    // power state machine
    // -------------------------------------------------------------
    case (st.pwr)
      PWR_NORMAL: begin
        if (wr_pm && i_bus.wdata[POS_STATE +: 2] != PS_NORMAL
            && i_bus.wdata[POS_STATE +: 2] != PS_RESERVED) begin
          next_st.state_sel = i_bus.wdata[POS_STATE +: 2];
          next_st.pwr = PWR_SLEEP;
          next_st.ready = 1'b0;
        end
      end
      PWR_SLEEP: begin
        if (wr_bot || wol_hit || ed_hit) begin
          next_st.pwr = PWR_WAKING;
          // the settle count gives the core time to come alive before ready shows
          next_st.rdy_cnt = 5'(READY_DELAY_CYCLES);
        end
      end
      PWR_WAKING: begin
        if (st.rdy_cnt == 5'h0_0) begin
          next_st.pwr = PWR_NORMAL;
          next_st.state_sel = PS_NORMAL;
          next_st.ready = 1'b1;
          next_st.read_seen = 1'b0;
        end else begin
          next_st.rdy_cnt = st.rdy_cnt - 5'h0_1;
        end
      end
      default: next_st.pwr = PWR_NORMAL;
    endcase
    // -------------------------------------------------------------
    // control fields
    // -------------------------------------------------------------
    if (wr_pm) begin
      next_st.wake_on_lan_enable = i_bus.wdata[POS_WAKE_ON_LAN_ENABLE];
      next_st.energy_detect_enable = i_bus.wdata[POS_ENERGY_DETECT_ENABLE];
      next_st.drv_type = i_bus.wdata[POS_DRV_TYPE];
      next_st.pulse_mode = i_bus.wdata[POS_PULSE_MODE];
      next_st.polarity = i_bus.wdata[POS_POLARITY];
      next_st.out_en = i_bus.wdata[POS_OUT_EN];
    end
    // phy reset: self-timed, a write cannot start, stop or restart it while it runs
    if (st.phy_reset_request) begin
      if (st.phy_cnt == 32'h0000_0000) begin
        next_st.phy_reset_request = 1'b0;
      end else begin
        next_st.phy_cnt = st.phy_cnt - 32'h0000_0001;
      end
    end else if (wr_pm && i_bus.wdata[POS_PHY_RESET_REQUEST]) begin
      next_st.phy_reset_request = 1'b1;
      // loaded one short: the cycle at count zero is the last cycle held, release comes on the edge after it
      next_st.phy_cnt = 32'(PHY_RESET_REQUEST_LEN - 1);
    end
    // wake cause: clear by write-one only when normal and quiet, a new event wins
    if (wr_pm && st.pwr == PWR_NORMAL && !i_events_pending) begin
      next_st.cause = st.cause & ~i_bus.wdata[POS_WAKE_CAUSE +: 2];
    end
    if (ed_hit) begin
      next_st.cause[0] = 1'b1;
    end
    if (wol_hit) begin
      next_st.cause[1] = 1'b1;
    end
    // -------------------------------------------------------------
    // wake output and internal interrupt
    // -------------------------------------------------------------
    // the interrupt ignores the pin enable, so software still sees a wake with the pin off
    next_st.irq = (next_st.cause[0] && next_st.energy_detect_enable) || (next_st.cause[1] && next_st.wake_on_lan_enable);
    if (st.pulse_mode) begin
      if (wol_hit || ed_hit) begin
        next_st.pulse_cnt = 32'(WAKE_PULSE_LEN - 1);
        next_st.wake_active = 1'b1;
      end else if (st.pulse_cnt != 32'h0000_0000) begin
        next_st.pulse_cnt = st.pulse_cnt - 32'h0000_0001;
      end else begin
        next_st.wake_active = 1'b0;
      end
    end else begin
      next_st.pulse_cnt = '0;
      next_st.wake_active = next_st.irq;
    end
    // pin value and enable come from next values so they move together with the flag
    asserted = next_st.wake_active && next_st.out_en;
    if (!next_st.drv_type) begin
      // open-drain: pull low when asserted, release otherwise
      next_st.pin_out = 1'b0;
      next_st.pin_oe = asserted;
    end else begin
      next_st.pin_out = next_st.polarity ? asserted : !asserted;
      next_st.pin_oe = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
      // the bank needs no settling of its own after reset, so it comes up ready
      st.ready <= 1'b1;
      st.pin_out <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_phy_reset = st.phy_reset_request;
  assign o_power_state = st.state_sel;
  assign o_wake_internal_interrupt = st.irq;
  assign o_wake_event_output = st.pin_out;
  assign o_wake_event_output_en = st.pin_oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_write_locked: assert property (i_bus.wr && !st.read_seen && i_bus.addr == OFS_POWER_MGMT
    |=> $stable(st.wake_on_lan_enable) && $stable(st.out_en)) else $error("write acted before first read");
  a_phy_start: assert property ($rose(o_phy_reset) |-> o_phy_reset [*8])
    else $error("phy reset too short");
  a_phy_rewrite: assert property (st.phy_reset_request && st.phy_cnt != 0 |=> st.phy_reset_request)
    else $error("phy reset cut short");
  a_wol_irq: assert property (i_wol_event && st.wake_on_lan_enable |=> st.cause[1] ##0 o_wake_internal_interrupt)
    else $error("wol event lost");
  a_ed_irq: assert property (i_energy_event && st.energy_detect_enable |=> st.cause[0] ##0 o_wake_internal_interrupt)
    else $error("energy event lost");
  a_open_drain: assert property (!st.drv_type |-> !o_wake_event_output)
    else $error("open drain drove high");
  a_pin_gated: assert property (!st.out_en && !st.phy_reset_request |-> !(st.pin_oe && !st.drv_type))
    else $error("pin driven while disabled");
  a_cause_hold: assert property (st.pwr != PWR_NORMAL && !i_energy_event |=> $past(st.cause[0]) <= st.cause[0])
    else $error("cause cleared while asleep");
  a_pm_readable: assert property (i_bus.rd && i_bus.addr == OFS_POWER_MGMT && !st.ready |=> o_rdata[POS_READY] == 1'b0
    && o_rdata[31:14] == 18'h0) else $error("power register unreadable asleep");
  a_sleep_wake: assert property (st.pwr == PWR_SLEEP && i_bus.wr && i_bus.addr == OFS_BYTE_ORDER_TEST
    |=> st.pwr == PWR_WAKING) else $error("byte test write did not wake");

  // ---------------------------------------------------------------
  // read path checks
  // ---------------------------------------------------------------
  a_rdata_idle: assert property (
    !i_bus.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data left standing");
  a_rsvd_upper: assert property (
    i_bus.rd |=> o_rdata[31:24] == 8'h00)
    else $error("reserved bits read nonzero");
  a_rx_levels: assert property (
    i_bus.rd && st.ready && i_bus.addr == OFS_RX_FIFO_LEVELS |=> o_rdata[23:0] == {$past(i_levels.rx_status_words_used), $past(i_levels.rx_data_bytes_used)})
    else $error("rx levels misreported");
  a_tx_levels: assert property (
    i_bus.rd && st.ready && i_bus.addr == OFS_TX_FIFO_LEVELS |=> o_rdata[23:0] == {$past(i_levels.tx_status_words_used), $past(i_levels.tx_data_bytes_free)})
    else $error("tx levels misreported");
  a_fifo_hidden: assert property (
    i_bus.rd && !st.ready && i_bus.addr != OFS_POWER_MGMT |=> o_rdata == 32'h0000_0000)
    else $error("register visible while not ready");
  a_ready_bit: assert property (
    i_bus.rd && i_bus.addr == OFS_POWER_MGMT |=> o_rdata[POS_READY] == $past(st.ready))
    else $error("ready bit misreported");

  // ---------------------------------------------------------------
  // power state checks
  // ---------------------------------------------------------------
  a_state_legal: assert property (
    o_power_state != PS_RESERVED)
    else $error("reserved power state entered");
  a_sleep_entry: assert property (
    wr_pm && st.pwr == PWR_NORMAL && i_bus.wdata[POS_STATE +: 2] == PS_ENERGY |=> o_power_state == PS_ENERGY && !st.ready)
    else $error("energy state not entered");
  a_reserved_state: assert property (
    wr_pm && st.pwr == PWR_NORMAL && i_bus.wdata[POS_STATE +: 2] == PS_RESERVED |=> st.pwr == PWR_NORMAL)
    else $error("reserved state accepted");
  a_wake_settle: assert property (
    st.pwr == PWR_WAKING && st.rdy_cnt == 5'h0_0 |=> st.ready && !st.read_seen && o_power_state == PS_NORMAL)
    else $error("wake did not settle to ready");
  a_asleep_locked: assert property (
    !st.ready && i_bus.wr && i_bus.addr == OFS_POWER_MGMT |=> $stable(st.energy_detect_enable) && $stable(st.polarity))
    else $error("power write acted while not ready");

  // ---------------------------------------------------------------
  // phy reset checks
  // ---------------------------------------------------------------
  a_phy_load: assert property (
    $rose(o_phy_reset) |-> st.phy_cnt == PHY_RESET_REQUEST_LEN - 1)
    else $error("phy reset length not loaded");
  a_phy_count: assert property (
    st.phy_reset_request && st.phy_cnt != 0 |=> st.phy_cnt == $past(st.phy_cnt) - 1)
    else $error("phy reset count skipped");
  a_phy_release: assert property (
    $fell(o_phy_reset) |-> $past(st.phy_cnt) == 0)
    else $error("phy reset released early");

  // ---------------------------------------------------------------
  // wake output checks
  // ---------------------------------------------------------------
  a_irq_source: assert property (
    o_wake_internal_interrupt |-> (st.cause[0] && st.energy_detect_enable) || (st.cause[1] && st.wake_on_lan_enable))
    else $error("interrupt without enabled cause");
  a_irq_no_pin: assert property (
    wol_hit && !st.out_en && !wr_pm |=> o_wake_internal_interrupt)
    else $error("interrupt gated by pin enable");
  a_push_pull_en: assert property (
    st.drv_type |-> o_wake_event_output_en)
    else $error("push-pull pin not driven");
  a_od_drive: assert property (
    !st.drv_type |-> o_wake_event_output_en == (st.wake_active && st.out_en))
    else $error("open drain enable wrong");
  a_pol_high: assert property (
    st.drv_type && st.polarity |-> o_wake_event_output == (st.wake_active && st.out_en))
    else $error("active high pin wrong");
  a_pol_low: assert property (
    st.drv_type && !st.polarity |-> o_wake_event_output == !(st.wake_active && st.out_en))
    else $error("active low pin wrong");
  a_pulse_hold: assert property (
    st.pulse_mode && st.wake_active && st.pulse_cnt != 0 && !wr_pm |=> st.wake_active)
    else $error("wake pulse cut short");
  a_pulse_start: assert property (
    st.pulse_mode && (wol_hit || ed_hit) |=> st.wake_active && st.pulse_cnt == WAKE_PULSE_LEN - 1)
    else $error("wake pulse not started");
  a_static_drop: assert property (
    !st.pulse_mode && !next_st.irq |=> !st.wake_active)
    else $error("static wake output stuck");
  a_clear_blocked: assert property (
    wr_pm && i_events_pending |=> ($past(st.cause) & ~st.cause) == 2'b00)
    else $error("cause cleared with events pending");
  a_clear_done: assert property (
    wr_pm && st.pwr == PWR_NORMAL && !i_events_pending && i_bus.wdata[POS_WAKE_CAUSE +: 2] == 2'b11 && !wol_hit && !ed_hit |=> st.cause == 2'b00)
    else $error("cause not cleared by write-one");

  c_sleep: cover property (st.pwr == PWR_SLEEP);
  c_wake_ready: cover property (st.pwr == PWR_WAKING ##1 st.pwr == PWR_NORMAL);
  c_phy_done: cover property ($fell(o_phy_reset));
  c_pulse: cover property (st.pulse_mode && $fell(st.wake_active));
  c_cause_clear: cover property (st.cause != 2'b00 ##1 st.cause == 2'b00);
endmodule

//--- flpm_host.sv
// host processor model driving the register port
`timescale 1ns/10ps
module flpm_host (
  input wire logic i_mclk,
  output flpm_pkg::flpm_bus_req_t o_bus
);
  import flpm_pkg::*;
  initial o_bus = '0;
  // released address and data lines show the inverse of the last value, never a stale copy
  task automatic idle();
    o_bus <= '{addr: ~o_bus.addr, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b0};
  endtask
  // no tx data is ever pushed here, so the free byte count is never overrun
  // the caller writes before the first read after reset and after wake to check the lock, and writes only the byte-order test while not ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    idle();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    o_bus <= '{addr: a, wdata: o_bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    idle();
  endtask
endmodule

//--- testbench.sv
// self-checking bench for the fifo level / power register bank
`timescale 1ns/10ps
module testbench;
  import flpm_pkg::*;
  logic i_mclk;
  logic i_rstn;
  flpm_bus_req_t bus;
  flpm_levels_t lv;
  logic wol;
  logic ed;
  logic pend;
  logic [31:0] rdata;
  logic phy_reset_request;
  logic [1:0] pstate;
  logic irq;
  logic pin;
  logic pin_en;
  logic rd_q;
  logic [31:0] exp_q[$];
  int error_cnt;
  int checked;
  int seed;
  // ------------------------------------------------------------
  // design, host model and clock
  // ------------------------------------------------------------
  flpm_regs #(.PHY_RESET_REQUEST_LEN(20), .WAKE_PULSE_LEN(50)) dut_u (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata), .i_levels(lv),
    .i_wol_event(wol), .i_energy_event(ed), .i_events_pending(pend), .o_phy_reset(phy_reset_request),
    .o_power_state(pstate), .o_wake_internal_interrupt(irq), .o_wake_event_output(pin),
    .o_wake_event_output_en(pin_en)
  );
  flpm_host host_u (.i_mclk(i_mclk), .o_bus(bus));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask
  // read data stand only in the cycle after the strobe, so they are looked at there
  always @(posedge i_mclk) begin
    rd_q <= bus.rd;
  end
  always @(negedge i_mclk) begin
    if (rd_q === 1'b1) begin
      check("read data", rdata, exp_q.pop_front());
    end
  end
  task automatic pulse(input int which);
    @(posedge i_mclk);
    if (which == 0) wol <= 1'b1;
    else ed <= 1'b1;
    @(posedge i_mclk);
    wol <= 1'b0;
    ed <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    summarize();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 32'h7bf2;
    i_rstn = 1'b0;
    wol = 1'b0;
    ed = 1'b0;
    pend = 1'b0;
    rd_q = 1'b0;
    lv = '{8'h00, 16'h0000, 8'h00, TX_FREE_RESET};
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    host_u.wr(OFS_POWER_MGMT, 32'h0000_0346);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0001);
    rd_exp(OFS_TX_FIFO_LEVELS, {16'h0000, TX_FREE_RESET});
    for (int i = 0; i < 4; i++) begin
      @(posedge i_mclk);
      lv <= $random(seed);
      @(posedge i_mclk);
      rd_exp(OFS_RX_FIFO_LEVELS, {8'h00, lv.rx_status_words_used, lv.rx_data_bytes_used});
      rd_exp(OFS_TX_FIFO_LEVELS, {8'h00, lv.tx_status_words_used, lv.tx_data_bytes_free});
    end
    rd_exp(8'h88, 32'h0000_0000);
    // wake events of both kinds, then a blocked and a granted clear
    host_u.wr(OFS_POWER_MGMT, 32'hffff_c3c6);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0347);
    pulse(0);
    pulse(1);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0377);
    @(negedge i_mclk);
    check("irq", irq, 1'b1);
    check("pin", {pin, pin_en}, 2'b11);
    @(posedge i_mclk);
    pend <= 1'b1;
    host_u.wr(OFS_POWER_MGMT, 32'h0000_0376);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0377);
    pend <= 1'b0;
    host_u.wr(OFS_POWER_MGMT, 32'h0000_0376);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0347);
    @(negedge i_mclk);
    check("pin cleared", {irq, pin}, 2'b00);
    // self-timed phy reset, with a write ignored while it runs
    host_u.wr(OFS_POWER_MGMT, 32'h0000_0747);
    @(negedge i_mclk);
    check("phy reset", phy_reset_request, 1'b1);
    host_u.wr(OFS_POWER_MGMT, 32'h0000_0346);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0747);
    repeat (30) @(posedge i_mclk);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0347);
    @(negedge i_mclk);
    check("phy released", phy_reset_request, 1'b0);
    // sleep, read while asleep, wake by byte-order write, write needs a new read
    host_u.wr(OFS_POWER_MGMT, 32'h0000_1347);
    @(negedge i_mclk);
    check("power state", pstate, PS_WAKE_FRAME);
    rd_exp(OFS_POWER_MGMT, 32'h0000_1346);
    host_u.wr(OFS_BYTE_ORDER_TEST, $random(seed));
    repeat (25) @(posedge i_mclk);
    @(negedge i_mclk);
    check("awake", pstate, PS_NORMAL);
    host_u.wr(OFS_POWER_MGMT, 32'h0000_0000);
    rd_exp(OFS_POWER_MGMT, 32'h0000_0347);
    // pulsed wake output runs its own length, the interrupt stays with the cause
    host_u.wr(OFS_POWER_MGMT, 32'h0000_034e);
    pulse(0);
    @(negedge i_mclk);
    check("pulse pin", {pin, pin_en}, 2'b11);
    repeat (60) @(posedge i_mclk);
    @(negedge i_mclk);
    check("pulse end", {irq, pin}, 2'b10);
    repeat (3) @(posedge i_mclk);
    summarize();
  end
endmodule
